// *** logic/tfc_tx_framing.sv ***
`timescale 1ns/1ps
module tfc_tx_framing (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire tfc_pkg::tfc_cfg_t cfg_i,
    input wire logic tx_reset_b_i,
    input wire logic tx_bit_rise_i,
    input wire logic tx_bit_fall_i,
    input wire logic rx_bit_fall_i,
    input wire logic generator_frame_pulse_i,
    input wire logic rx_frame_sync_pin_i,
    input wire logic tx_frame_sync_pin_i,
    output logic tx_frame_sync_pin_o,
    output logic tx_frame_sync_pin_oe_b_o,
    input wire logic buf_wr_i,
    input wire logic [tfc_pkg::WORD_BITS-1:0] buf_data_i,
    output logic tx_ready_flag_o,
    input wire logic mc_block_end_i,
    input wire logic sync_err_clear_i,
    output logic tx_sync_error_flag_o,
    output logic tx_interrupt_o,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_b_o,
    output logic rx_first_sample_o
);

    tfc_pkg::tfc_state_t q;
    tfc_pkg::tfc_state_t next_q;
    logic fs_int;
    logic fstart;
    logic start;
    logic abort;
    logic zero_now;

    // ****************************************************
    // frame sync routing
    // ****************************************************
    tfc_fs_route u_route (
        .cfg_i(cfg_i),
        .tx_frame_sync_pin_i(tx_frame_sync_pin_i),
        .generator_frame_pulse_i(generator_frame_pulse_i),
        .rx_frame_sync_pin_i(rx_frame_sync_pin_i),
        .copy_fs_i(q.copy_fs),
        .spi_active_i(q.loaded),
        .fs_int_o(fs_int),
        .tx_frame_sync_pin_o(tx_frame_sync_pin_o),
        .tx_frame_sync_pin_oe_b_o(tx_frame_sync_pin_oe_b_o)
    );

    // frame start is the first falling bit edge with sync active
    assign fstart = tx_bit_fall_i && fs_int && !q.fs_seen
                    && tx_reset_b_i;
    assign start = fstart && (q.st == tfc_pkg::TFC_IDLE) && q.loaded;
    assign abort = fstart && (q.st != tfc_pkg::TFC_IDLE)
                   && !cfg_i.tx_frame_sync_ignore;

    // ****************************************************
    // next state
    // ****************************************************
    always_comb
    begin
        next_q = q;
        next_q.irq = 1'b0;
        next_q.rx_first = 1'b0;
        if (tx_bit_fall_i)
        begin
            next_q.fs_seen = fs_int;
        end
        if (!tx_reset_b_i)
        begin
            // transmitter held in reset: state idle, loaded word, buffer and copy pulse dropped
            next_q.st = tfc_pkg::TFC_IDLE;
            next_q.loaded = 1'b0;
            next_q.buf_full = 1'b0;
            next_q.copy_fs = 1'b0;
        end
        else
        begin
            if (buf_wr_i && !q.buf_full)
            begin
                next_q.buffer = buf_data_i;
                next_q.buf_full = 1'b1;
            end
            // generated pulse ends once the bit clock has seen it
            if (tx_bit_fall_i && q.copy_fs)
            begin
                next_q.copy_fs = 1'b0;
            end
            if (q.buf_full && !q.loaded && (q.st == tfc_pkg::TFC_IDLE))
            begin
                // first bit is placed on the pin ahead of the sync
                next_q.shreg = q.buffer;
                next_q.hold = q.buffer;
                next_q.dout = q.buffer[tfc_pkg::WORD_BITS-1];
                next_q.loaded = 1'b1;
                next_q.buf_full = 1'b0;
                next_q.copy_fs = cfg_i.tx_frame_sync_mode
                                 && !cfg_i.generator_frame_sync_mode;
            end
            if (start || abort)
            begin
                if (abort)
                begin
                    // reload the aborted word and resend it
                    next_q.shreg = q.hold;
                    next_q.dout = q.hold[tfc_pkg::WORD_BITS-1];
                end
                next_q.bits_left = tfc_pkg::LAST_BIT_COUNT;
                // reserved code behaves as the two bit delay
                next_q.delay_left = (cfg_i.tx_data_delay[1])
                                    ? tfc_pkg::DELAY_TWO
                                    : cfg_i.tx_data_delay;
                if (cfg_i.tx_data_delay == tfc_pkg::DELAY_ZERO)
                    next_q.st = tfc_pkg::TFC_SHIFT;
                else
                    next_q.st = tfc_pkg::TFC_DELAY;
                if (abort)
                    next_q.oe_cnt = cfg_i.data_out_delay_enable
                                    ? tfc_pkg::TURN_ON_CYCLES : 2'h0;
            end
            else if (tx_bit_rise_i)
            begin
                // bits after the first launch on the rising bit clock
                unique case (q.st)
                    tfc_pkg::TFC_DELAY:
                    begin
                        // with two bits, the framing bit slot is skipped
                        next_q.delay_left = q.delay_left - 2'h1;
                        if (q.delay_left == 2'h1)
                        begin
                            next_q.st = tfc_pkg::TFC_SHIFT;
                            next_q.dout =
                                q.shreg[tfc_pkg::WORD_BITS-1];
                        end
                    end
                    tfc_pkg::TFC_SHIFT:
                    begin
                        if (q.bits_left == 4'h0)
                        begin
                            next_q.st = tfc_pkg::TFC_IDLE;
                            next_q.loaded = 1'b0;
                        end
                        else
                        begin
                            next_q.shreg = {q.shreg[tfc_pkg::WORD_BITS-2:0],
                                            1'b0};
                            next_q.dout =
                                q.shreg[tfc_pkg::WORD_BITS-2];
                            next_q.bits_left = q.bits_left - 4'h1;
                        end
                    end
                    tfc_pkg::TFC_IDLE:
                    begin
                        next_q.st = tfc_pkg::TFC_IDLE;
                    end
                    default:
                    begin
                        next_q.st = tfc_pkg::TFC_IDLE;
                    end
                endcase
            end
        end
        // turn-on delay rearms between words, counts only on the first bit
        if (q.st == tfc_pkg::TFC_IDLE)
            next_q.oe_cnt = cfg_i.data_out_delay_enable
                            ? tfc_pkg::TURN_ON_CYCLES : 2'h0;
        else if ((q.st == tfc_pkg::TFC_SHIFT) && (q.oe_cnt != 2'h0))
            next_q.oe_cnt = q.oe_cnt - 2'h1;
        // software clear loses to a new error in the same cycle
        if (sync_err_clear_i)
            next_q.sync_err = 1'b0;
        if (abort)
            next_q.sync_err = 1'b1;
        // sync sampled on the core clock, even with the transmitter reset
        next_q.fs_cpu = fs_int;
        unique case (cfg_i.tx_interrupt_mode)
            tfc_pkg::IRQ_READY:
                next_q.irq = q.buf_full && !next_q.buf_full;
            tfc_pkg::IRQ_BLOCK:
                next_q.irq = cfg_i.multichannel_enable
                             && mc_block_end_i;
            tfc_pkg::IRQ_FRAME:
                next_q.irq = fs_int && !q.fs_cpu;
            tfc_pkg::IRQ_SYNC_ERR:
                next_q.irq = !q.sync_err && next_q.sync_err;
        endcase
        // receive side: zero delay samples on the detecting edge
        if (rx_bit_fall_i)
        begin
            next_q.rx_fs_seen = rx_frame_sync_pin_i;
            next_q.rx_first = rx_frame_sync_pin_i && !q.rx_fs_seen
                && (cfg_i.tx_data_delay == tfc_pkg::DELAY_ZERO);
        end
    end

    // ****************************************************
    // state register
    // ****************************************************
    always_ff @(posedge core_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            q <= '0;
        else
            q <= next_q;
    end

    // ****************************************************
    // outputs
    // ****************************************************
    // zero delay: pin turns on as soon as sync is seen, no edge wait
    assign zero_now = (q.st == tfc_pkg::TFC_IDLE) && q.loaded && fs_int
                      && (cfg_i.tx_data_delay == tfc_pkg::DELAY_ZERO)
                      && tx_reset_b_i;
    assign serial_data_out_oe_b_o = !(((q.st == tfc_pkg::TFC_SHIFT)
                                       || zero_now)
                                      && (q.oe_cnt == 2'h0));
    assign serial_data_out_o = q.dout;
    assign tx_ready_flag_o = !q.buf_full;
    assign tx_sync_error_flag_o = q.sync_err;
    assign tx_interrupt_o = q.irq;
    assign rx_first_sample_o = q.rx_first;

    // ****************************************************
    // checks
    // ****************************************************
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    ready_drop_a: assert property (
        buf_wr_i && tx_ready_flag_o && tx_reset_b_i |=> !tx_ready_flag_o)
        else $error("ready flag stayed high after write");
    zero_delay_a: assert property (
        start && cfg_i.tx_data_delay == tfc_pkg::DELAY_ZERO
        |=> q.st == tfc_pkg::TFC_SHIFT && q.bits_left == 4'hf)
        else $error("zero delay did not start shifting");
    two_delay_a: assert property (
        start && cfg_i.tx_data_delay == tfc_pkg::DELAY_TWO
        |=> q.st == tfc_pkg::TFC_DELAY && q.delay_left == 2'h2)
        else $error("two bit delay not loaded");
    sync_error_a: assert property (
        abort |=> tx_sync_error_flag_o && q.shreg == $past(q.hold))
        else $error("unexpected sync not flagged or word not reloaded");
    ready_irq_a: assert property (
        cfg_i.tx_interrupt_mode == tfc_pkg::IRQ_READY
        && $stable(cfg_i) && $rose(tx_ready_flag_o) |-> tx_interrupt_o)
        else $error("no interrupt on ready rise");
    err_irq_a: assert property (
        cfg_i.tx_interrupt_mode == tfc_pkg::IRQ_SYNC_ERR && $stable(cfg_i)
        && $rose(tx_sync_error_flag_o) |-> tx_interrupt_o)
        else $error("no interrupt on sync error");
    gen_pin_a: assert property (
        cfg_i.tx_frame_sync_mode && cfg_i.generator_frame_sync_mode
        && !cfg_i.generator_sync_select
        |-> !tx_frame_sync_pin_oe_b_o && tx_frame_sync_pin_o ==
            (generator_frame_pulse_i ^ cfg_i.tx_frame_sync_polarity))
        else $error("generator pulse not driven on sync pin");
    sync_input_a: assert property (
        !cfg_i.tx_frame_sync_mode |-> tx_frame_sync_pin_oe_b_o
        && fs_int == (tx_frame_sync_pin_i ^ cfg_i.tx_frame_sync_polarity))
        else $error("sync pin not an input");
    turn_on_a: assert property (
        cfg_i.data_out_delay_enable && $stable(cfg_i)
        && q.st != tfc_pkg::TFC_SHIFT
        ##1 q.st == tfc_pkg::TFC_SHIFT |-> serial_data_out_oe_b_o)
        else $error("first bit turned on without delay");

    // ****************************************************
    // launch, sync source, interrupt and error flag checks
    // ****************************************************
    one_delay_a: assert property (
        start && cfg_i.tx_data_delay == 2'h1
        |=> q.st == tfc_pkg::TFC_DELAY && q.delay_left == 2'h1)
        else $error("one bit delay not loaded");
    zero_drive_a: assert property (
        cfg_i.tx_data_delay == tfc_pkg::DELAY_ZERO
        && !cfg_i.data_out_delay_enable && $stable(cfg_i) && tx_reset_b_i
        && q.st == tfc_pkg::TFC_IDLE && q.loaded && fs_int
        |-> !serial_data_out_oe_b_o
            && serial_data_out_o == q.hold[tfc_pkg::WORD_BITS-1])
        else $error("zero delay first bit not driven at once");
    launch_rise_a: assert property (
        q.st == tfc_pkg::TFC_SHIFT && $past(q.st) == tfc_pkg::TFC_SHIFT
        && $changed(serial_data_out_o) |-> $past(tx_bit_rise_i || abort))
        else $error("data bit changed away from a rising bit edge");
    copy_pulse_a: assert property (
        cfg_i.tx_frame_sync_mode && !cfg_i.generator_frame_sync_mode
        && $stable(cfg_i) && $rose(q.loaded) |-> fs_int)
        else $error("buffer copy raised no frame sync");
    copy_end_a: assert property (
        q.copy_fs && tx_bit_fall_i |=> !q.copy_fs)
        else $error("copy frame sync wider than one bit");
    spi_enable_a: assert property (
        cfg_i.tx_frame_sync_mode && !cfg_i.generator_frame_sync_mode
        && cfg_i.clock_stop_mode[1] && cfg_i.spi_master
        && q.st != tfc_pkg::TFC_IDLE
        |-> !tx_frame_sync_pin_oe_b_o
            && tx_frame_sync_pin_o != cfg_i.tx_frame_sync_polarity)
        else $error("slave enable dropped during a word");
    frame_irq_a: assert property (
        cfg_i.tx_interrupt_mode == tfc_pkg::IRQ_FRAME && $stable(cfg_i)
        && $rose(fs_int) |=> tx_interrupt_o)
        else $error("no interrupt on frame sync");
    block_irq_a: assert property (
        cfg_i.tx_interrupt_mode == tfc_pkg::IRQ_BLOCK && mc_block_end_i
        |=> tx_interrupt_o == $past(cfg_i.multichannel_enable))
        else $error("block interrupt wrong for transfer mode");
    err_sticky_a: assert property (
        tx_sync_error_flag_o && !sync_err_clear_i |=> tx_sync_error_flag_o)
        else $error("sync error flag lost without a clear");

endmodule : tfc_tx_framing

// *** logic/tfc_pkg.sv ***
// Summary of operation
// - delay code 00/01/10 gives 0/1/2 bit delay
// - frame starts where sync first seen active
// - zero delay drives preloaded first bit at once
// - zero delay receive samples first bit immediately
// - two bit delay skips the framing bit
// - delay enable postpones first bit turn-on only
// - mode 00 interrupts on ready rising
// - mode 01 interrupts on multichannel block ends
// - mode 10 interrupts on each frame sync
// - mode 11 interrupts on sync error set
// - mode bit 0 makes sync pin input
// - generator pulse drives sync when both set
// - generator mode only matters with mode bit 1
// - spi master drives slave enable per transfer
// - generator sync bit picks pulse source
// - internal sync active high, polarity inverts
// - data bits launch on transmit clock rise
// - unexpected sync aborts, flags error, resends
package tfc_pkg;

    // ****************************************************
    // field positions and reset values
    // ****************************************************
    localparam int TX_DATA_DELAY_LSB = 0;
    localparam int DATA_OUT_DELAY_ENABLE_BIT = 7;
    localparam int TX_INTERRUPT_MODE_LSB = 4;
    localparam int TX_FRAME_SYNC_MODE_BIT = 11;
    localparam int GENERATOR_FRAME_SYNC_MODE_BIT = 12;
    localparam logic [1:0] TX_DATA_DELAY_RESET = 2'h0;
    localparam logic [1:0] TX_INTERRUPT_MODE_RESET = 2'h0;
    localparam logic FLAG_RESET = 1'b0;

    // ****************************************************
    // codes and timing
    // ****************************************************
    localparam logic [1:0] DELAY_ZERO = 2'h0;
    localparam logic [1:0] DELAY_TWO = 2'h2;
    localparam logic [1:0] IRQ_READY = 2'h0;
    localparam logic [1:0] IRQ_BLOCK = 2'h1;
    localparam logic [1:0] IRQ_FRAME = 2'h2;
    localparam logic [1:0] IRQ_SYNC_ERR = 2'h3;
    localparam int WORD_BITS = 16;
    localparam logic [3:0] LAST_BIT_COUNT = 4'hf;
    localparam int CORE_CLK_MHZ = 250;
    localparam int TURN_ON_DELAY_NS = 8;
    localparam int TURN_ON_CYCLES_INT =
        (TURN_ON_DELAY_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam logic [1:0] TURN_ON_CYCLES = TURN_ON_CYCLES_INT[1:0];

    typedef enum logic [1:0] {
        TFC_IDLE = 2'b00,
        TFC_DELAY = 2'b01,
        TFC_SHIFT = 2'b10
    } tfc_tx_st_t;

    typedef struct packed {
        logic [1:0] tx_data_delay;
        logic data_out_delay_enable;
        logic [1:0] tx_interrupt_mode;
        logic tx_frame_sync_mode;
        logic generator_frame_sync_mode;
        logic tx_frame_sync_polarity;
        logic tx_frame_sync_ignore;
        logic [1:0] clock_stop_mode;
        logic spi_master;
        logic generator_sync_select;
        logic multichannel_enable;
    } tfc_cfg_t;

    typedef struct packed {
        tfc_tx_st_t st;
        logic [WORD_BITS-1:0] shreg;
        logic [WORD_BITS-1:0] hold;
        logic [WORD_BITS-1:0] buffer;
        logic buf_full;
        logic loaded;
        logic [1:0] delay_left;
        logic [3:0] bits_left;
        logic fs_seen;
        logic fs_cpu;
        logic copy_fs;
        logic sync_err;
        logic dout;
        logic [1:0] oe_cnt;
        logic irq;
        logic rx_fs_seen;
        logic rx_first;
    } tfc_state_t;

endpackage : tfc_pkg

// *** logic/tfc_fs_route.sv ***
`timescale 1ns/1ps
module tfc_fs_route (
    input wire tfc_pkg::tfc_cfg_t cfg_i,
    input wire logic tx_frame_sync_pin_i,
    input wire logic generator_frame_pulse_i,
    input wire logic rx_frame_sync_pin_i,
    input wire logic copy_fs_i,
    input wire logic spi_active_i,
    output logic fs_int_o,
    output logic tx_frame_sync_pin_o,
    output logic tx_frame_sync_pin_oe_b_o
);

    logic gen_fs;
    logic own_fs;
    logic spi_mode;

    // ****************************************************
    // source selection
    // ****************************************************
    // generator pulse may be slaved to the receive sync pin
    assign gen_fs = cfg_i.generator_sync_select
                    ? rx_frame_sync_pin_i
                    : generator_frame_pulse_i;
    assign spi_mode = cfg_i.clock_stop_mode[1] && cfg_i.spi_master;

    // generator pulse, else slave enable held for the whole word, else copy pulse
    always_comb
    begin
        if (cfg_i.generator_frame_sync_mode)
            own_fs = gen_fs;
        else if (spi_mode)
            own_fs = spi_active_i;
        else
            own_fs = copy_fs_i;
    end

    // internal sync is active high; polarity inverts both ways
    always_comb
    begin
        if (cfg_i.tx_frame_sync_mode)
        begin
            fs_int_o = own_fs;
            tx_frame_sync_pin_o = own_fs
                                  ^ cfg_i.tx_frame_sync_polarity;
            tx_frame_sync_pin_oe_b_o = 1'b0;
        end
        else
        begin
            // spi slave enable also arrives here
            fs_int_o = tx_frame_sync_pin_i
                       ^ cfg_i.tx_frame_sync_polarity;
            tx_frame_sync_pin_o = 1'b0;
            tx_frame_sync_pin_oe_b_o = 1'b1;
        end
    end

endmodule : tfc_fs_route

// *** test/tfc_codec_model.sv ***
`timescale 1ns/1ps
// ****************************************
// far-side codec: sync source, bit catcher
// ****************************************
module tfc_codec_model (
    input wire logic core_clk_i,
    input wire logic tx_bit_rise_i,
    input wire logic tx_bit_fall_i,
    input wire logic fs_int_i,
    input wire logic data_i,
    input wire logic data_oe_b_i,
    input wire logic [1:0] delay_i,
    output logic ext_fs_o,
    output logic [15:0] word_o,
    output logic [4:0] nbits_o,
    output logic [1:0] skip_o
);
    logic fs_prev;

    // idle: sync inactive, nothing caught yet
    initial
    begin
        ext_fs_o = 1'b0;
        fs_prev = 1'b0;
        word_o = 16'h0;
        nbits_o = 5'h0;
        skip_o = 2'h0;
    end

    // catch on the falling bit clock, away from the launch edge
    always @(posedge core_clk_i)
    begin
        if (tx_bit_fall_i)
        begin
            if (fs_int_i && !fs_prev)
            begin
                nbits_o = 5'h0;
                skip_o = 2'h0;
            end
            fs_prev = fs_int_i;
            // a released data pin is never sampled; slots ahead of the
            // agreed delay hold an aborted word or the framing bit
            if (!data_oe_b_i && nbits_o < 5'h10
                && (nbits_o != 5'h0 || skip_o >= delay_i))
            begin
                word_o = {word_o[14:0], data_i};
                nbits_o = nbits_o + 5'h1;
            end
            else if (nbits_o == 5'h0 && skip_o < 2'h3)
                skip_o = skip_o + 2'h1;
        end
    end

    // one bit wide sync, raised clear of the sampling fall
    task automatic send_sync(input logic pol);
        @(posedge core_clk_i iff tx_bit_rise_i);
        @(negedge core_clk_i);
        ext_fs_o = !pol;
        @(posedge core_clk_i iff tx_bit_rise_i);
        @(negedge core_clk_i);
        ext_fs_o = pol;
    endtask : send_sync
endmodule : tfc_codec_model

// *** test/tfc_tx_framing_tb_top.sv ***
`timescale 1ns/1ps
module tfc_tx_framing_tb_top;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    tfc_pkg::tfc_cfg_t cfg = '0;
    logic tx_rst_b = 1'b1;
    logic rise = 1'b0;
    logic fall = 1'b0;
    logic gen_pulse = 1'b0;
    logic buf_wr = 1'b0;
    logic [15:0] buf_data = 16'h0;
    logic mc_end = 1'b0;
    logic err_clr = 1'b0;
    logic fs_o, fs_oe_b, ready, err, irq, dout, dout_oe_b, rx_first;
    logic ext_fs, fs_wire;
    logic fs_o_prev = 1'b0;
    logic [15:0] word;
    logic [4:0] nbits;
    logic [1:0] skip;
    logic [3:0] bcnt = 4'h0;
    int irq_cnt = 0;
    int rxf_cnt = 0;
    int fs_cnt = 0;
    int mismatches = 0;
    int num_checks = 0;

    always #2 core_clk = ~core_clk;

    // sync pin wire: the device when enabled, else the codec
    assign fs_wire = fs_oe_b ? ext_fs : fs_o;

    tfc_tx_framing u_tfc_tx_framing (
        .core_clk_i(core_clk), .rst_b_i(rst_b), .cfg_i(cfg),
        .tx_reset_b_i(tx_rst_b), .tx_bit_rise_i(rise),
        .tx_bit_fall_i(fall), .rx_bit_fall_i(fall),
        .generator_frame_pulse_i(gen_pulse),
        .rx_frame_sync_pin_i(ext_fs), .tx_frame_sync_pin_i(fs_wire),
        .tx_frame_sync_pin_o(fs_o), .tx_frame_sync_pin_oe_b_o(fs_oe_b),
        .buf_wr_i(buf_wr), .buf_data_i(buf_data),
        .tx_ready_flag_o(ready), .mc_block_end_i(mc_end),
        .sync_err_clear_i(err_clr), .tx_sync_error_flag_o(err),
        .tx_interrupt_o(irq), .serial_data_out_o(dout),
        .serial_data_out_oe_b_o(dout_oe_b), .rx_first_sample_o(rx_first));

    tfc_codec_model u_tfc_codec_model (
        .core_clk_i(core_clk), .tx_bit_rise_i(rise), .tx_bit_fall_i(fall),
        .fs_int_i(fs_wire ^ cfg.tx_frame_sync_polarity), .data_i(dout),
        .data_oe_b_i(dout_oe_b), .delay_i(cfg.tx_data_delay),
        .ext_fs_o(ext_fs), .word_o(word),
        .nbits_o(nbits), .skip_o(skip));

    // bit clock strobes, 16 core cycles a bit so turn-on delay fits
    always @(negedge core_clk)
    begin
        bcnt <= bcnt + 4'h1;
        rise <= (bcnt == 4'hf);
        fall <= (bcnt == 4'h7);
    end

    // event counters for pulses too short to poll
    always @(posedge core_clk)
    begin
        irq_cnt <= irq_cnt + int'(irq === 1'b1);
        rxf_cnt <= rxf_cnt + int'(rx_first === 1'b1);
        fs_cnt <= fs_cnt + int'(!fs_oe_b && fs_o === 1'b1 && !fs_o_prev);
        fs_o_prev <= fs_o;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : check

    task automatic write_word(input logic [15:0] w);
        @(negedge core_clk);
        buf_data = w;
        buf_wr = 1'b1;
        @(negedge core_clk);
        buf_wr = 1'b0;
        check("ready", 16'h0, {15'h0, ready});
    endtask : write_word

    // bounded wait for the codec to hold n bits
    task automatic wait_bits(input logic [4:0] n);
        for (int i = 0; i < 600 && nbits != n; i++)
            @(negedge core_clk);
    endtask : wait_bits

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize

    // ****************************************
    // scenarios
    // ****************************************
    task automatic frame_test(input logic [1:0] d);
        logic [15:0] w;
        int i0;
        int r0;
        w = 16'ha5c3 ^ {14'h0, d};
        cfg = '0;
        cfg.tx_data_delay = d;
        cfg.data_out_delay_enable = d[0];
        i0 = irq_cnt;
        r0 = rxf_cnt;
        write_word(w);
        u_tfc_codec_model.send_sync(1'b0);
        wait_bits(5'h10);
        check("word", w, word);
        check("skip", {14'h0, d}, {14'h0, skip});
        check("irq", 16'h1, 16'(irq_cnt - i0));
        check("rxfirst", {15'h0, d == 2'h0}, 16'(rxf_cnt - r0));
        $display("test frame delay %0d done", d);
    endtask : frame_test

    task automatic irq_test();
        int i0;
        cfg = '0;
        cfg.tx_interrupt_mode = tfc_pkg::IRQ_FRAME;
        tx_rst_b = 1'b0;
        i0 = irq_cnt;
        u_tfc_codec_model.send_sync(1'b0);
        repeat (4) @(negedge core_clk);
        check("irq frame", 16'h1, 16'(irq_cnt - i0));
        tx_rst_b = 1'b1;
        cfg.tx_interrupt_mode = tfc_pkg::IRQ_BLOCK;
        for (int m = 0; m < 2; m++)
        begin
            cfg.multichannel_enable = m[0];
            i0 = irq_cnt;
            @(negedge core_clk);
            mc_end = 1'b1;
            @(negedge core_clk);
            mc_end = 1'b0;
            repeat (3) @(negedge core_clk);
            check("irq block", 16'(m), 16'(irq_cnt - i0));
        end
        $display("test irq done");
    endtask : irq_test

    // a second sync mid-word, first obeyed then ignored
    task automatic abort_test();
        int i0;
        for (int g = 0; g < 2; g++)
        begin
            cfg = '0;
            cfg.tx_data_delay = 2'h1;
            cfg.tx_interrupt_mode = tfc_pkg::IRQ_SYNC_ERR;
            cfg.tx_frame_sync_ignore = g[0];
            i0 = irq_cnt;
            write_word(16'h3c5a);
            u_tfc_codec_model.send_sync(1'b0);
            wait_bits(5'h5);
            u_tfc_codec_model.send_sync(1'b0);
            wait_bits(5'h10);
            check("err", 16'(1 - g), {15'h0, err});
            check("irq err", 16'(1 - g), 16'(irq_cnt - i0));
            if (g == 0)
                check("resent", 16'h3c5a, word);
            @(negedge core_clk);
            err_clr = 1'b1;
            @(negedge core_clk);
            err_clr = 1'b0;
        end
        $display("test abort done");
    endtask : abort_test

    task automatic fs_test();
        int f0;
        cfg = '0;
        cfg.generator_frame_sync_mode = 1'b1;
        @(negedge core_clk);
        check("fs in", 16'h1, {15'h0, fs_oe_b});
        cfg.tx_frame_sync_mode = 1'b1;
        cfg.tx_frame_sync_polarity = 1'b1;
        gen_pulse = 1'b1;
        @(negedge core_clk);
        check("fs gen", 16'h0, {14'h0, fs_oe_b, fs_o});
        // slaved generator follows the idle receive sync, not the pulse
        cfg.generator_sync_select = 1'b1;
        @(negedge core_clk);
        check("fs generator_sync_select", 16'h1, {14'h0, fs_oe_b, fs_o});
        cfg.generator_sync_select = 1'b0;
        gen_pulse = 1'b0;
        @(negedge core_clk);
        check("fs gen off", 16'h1, {14'h0, fs_oe_b, fs_o});
        cfg = '0;
        cfg.tx_frame_sync_mode = 1'b1;
        cfg.tx_data_delay = 2'h1;
        f0 = fs_cnt;
        write_word(16'h0ff0);
        wait_bits(5'h8);
        wait_bits(5'h10);
        check("copy word", 16'h0ff0, word);
        check("copy pulse", 16'h1, 16'(fs_cnt - f0));
        cfg.clock_stop_mode = 2'h3;
        cfg.spi_master = 1'b1;
        write_word(16'h1234);
        wait_bits(5'h8);
        check("slave en", 16'h1, {15'h0, fs_o});
        wait_bits(5'h10);
        check("spi word", 16'h1234, word);
        $display("test fs source done");
    endtask : fs_test

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial
    begin
        repeat (20) @(negedge core_clk);
        rst_b = 1'b1;
        @(negedge core_clk);
        // ready, error, interrupt, data enable straight out of reset
        check("reset", 16'ha, {12'h0, ready, err, dout_oe_b, irq});
        for (int d = 0; d < 3; d++)
            frame_test(2'(d));
        irq_test();
        abort_test();
        fs_test();
        summarize();
    end

    // the tests need some 3k cycles; 25k means a hang
    initial
    begin
        #100000;
        mismatches++;
        summarize();
    end
endmodule : tfc_tx_framing_tb_top
